/* File: dv/ahp_host_model.sv */
`timescale 1ns/1ps

// ****************************************
// Host processor on the parallel bus
// ****************************************
module ahp_host_model
(
   // Clock and bus style
   input  wire logic       clk,
   input  wire logic       ds_mode,
   // Host bus pins
   output logic            cs_n,
   output logic            rd_ds_n,
   output logic            wr_rw_n,
   output logic      [7:0] addr,
   output logic      [7:0] data_in,
   // Port drive
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe
);
   logic [7:0] drv_val;

   // one byte on the shared wire
   // Idle bus shows the inverse of the last byte so a stale value never passes for a read
   assign data_in = data_oe ? data_out : drv_val;

   initial
   begin
      cs_n    = 1'b1;
      rd_ds_n = 1'b1;
      wr_rw_n = 1'b1;
      addr    = 8'h00;
      drv_val = 8'h00;
   end

   task automatic access(input logic wr, input logic sel, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      cs_n    = ~sel;
      addr    = a;
      drv_val = d;
      wr_rw_n = ~wr;
      rd_ds_n = ds_mode ? 1'b0 : wr;
      // Strobe held six clocks, two more than the four a read needs
      repeat (6) @(posedge clk);
      // Read byte taken mid-cycle, clear of the edges that move it
      @(negedge clk);
      q       = data_in;
      rd_ds_n = 1'b1;
      // Direction and select outlive the strobe by one clock
      @(negedge clk);
      wr_rw_n = 1'b1;
      cs_n    = 1'b1;
      addr    = ~a;
      drv_val = ~d;
      repeat (5) @(negedge clk);
   endtask : access
endmodule : ahp_host_model

/* File: dv/test_async_parallel_host_port.sv */
`timescale 1ns/1ps

module test_async_parallel_host_port;
   import ahp_pkg::*;

   logic        clk;
   logic        rst_n;
   logic        cs_n;
   logic        rd_ds_n;
   logic        wr_rw_n;
   logic [7:0]  addr;
   logic [7:0]  data_in;
   logic [7:0]  data_out;
   logic        data_oe;
   logic        int_n_out;
   logic        int_n_oe;
   logic [1:0]  style;
   logic        hw_cfg;
   logic        ds_mode;
   ahp_req_t    req;
   logic [7:0]  user_rdata;
   logic [7:0]  events;
   logic        drv_hi;
   logic        oe_seen;
   logic [15:0] wr_last;
   int          wr_count;
   int          bad_count;
   int          check_count;

   ahp_host_port u_dut
   (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .cs_n                   (cs_n),
      .rd_ds_n                (rd_ds_n),
      .wr_rw_n                (wr_rw_n),
      .addr                   (addr),
      .data_in                (data_in),
      .data_out               (data_out),
      .data_oe                (data_oe),
      .int_n_out              (int_n_out),
      .int_n_oe               (int_n_oe),
      .bus_style_select       (style),
      .hardware_config_select (hw_cfg),
      .req                    (req),
      .user_rdata             (user_rdata),
      .status_events          (events),
      .irq_drive_high_sel     (drv_hi)
   );

   ahp_host_model u_host
   (
      .clk      (clk),
      .ds_mode  (ds_mode),
      .cs_n     (cs_n),
      .rd_ds_n  (rd_ds_n),
      .wr_rw_n  (wr_rw_n),
      .addr     (addr),
      .data_in  (data_in),
      .data_out (data_out),
      .data_oe  (data_oe)
   );

   // ****************************************
   // Clock, core model and monitors
   // ****************************************
   always #10 clk = ~clk;

   // Core answers with a byte derived from the address
   always @(negedge clk)
      user_rdata <= req.addr ^ 8'hA5;

   always @(posedge clk)
   begin
      if (req.wr === 1'b1)
      begin
         wr_count <= wr_count + 1;
         wr_last  <= {req.addr, req.wdata};
      end
      if (data_oe === 1'b1)
         oe_seen <= 1'b1;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      u_host.access(1'b0, 1'b1, a, 8'h00, q);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.access(1'b1, 1'b1, a, d, q);
   endtask : wr

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      repeat (4) @(negedge clk);
      check(16'({data_oe, int_n_oe, int_n_out, drv_hi}), 16'h0002);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      check(16'({data_oe, int_n_oe}), 16'h0000);
      $display("reset test done");
   endtask : t_reset

   task automatic t_style(input logic [1:0] s);
      logic [7:0] q;
      int         n;
      style   = s;
      ds_mode = s[0];
      repeat (3) @(negedge clk);
      n = wr_count;
      wr(8'h81, 8'h5E);
      check(16'(wr_count - n), 16'h0001);
      check(wr_last, 16'h815E);
      rd(8'h3C, q);
      check(16'(q), 16'h0099);
      rd(8'hFF, q);
      check(16'(q), 16'h005A);
      check(16'(data_oe), 16'h0000);
      $display("style %b test done", s);
   endtask : t_style

   task automatic t_ignored;
      logic [7:0] q;
      int         n;
      n       = wr_count;
      oe_seen = 1'b0;
      u_host.access(1'b1, 1'b0, 8'h22, 8'h33, q);
      u_host.access(1'b0, 1'b0, 8'h22, 8'h00, q);
      style   = 2'b01;
      ds_mode = 1'b1;
      repeat (3) @(negedge clk);
      u_host.access(1'b1, 1'b0, 8'h22, 8'h33, q);
      u_host.access(1'b0, 1'b0, 8'h22, 8'h00, q);
      style   = 2'b11;
      repeat (3) @(negedge clk);
      wr(8'h22, 8'h33);
      ds_mode = 1'b0;
      style = 2'b10;
      repeat (3) @(negedge clk);
      wr(8'h22, 8'h33);
      style  = 2'b00;
      hw_cfg = 1'b1;
      repeat (3) @(negedge clk);
      wr(8'h22, 8'h33);
      rd(8'h22, q);
      hw_cfg = 1'b0;
      repeat (3) @(negedge clk);
      check(16'(wr_count - n), 16'h0000);
      check(16'(oe_seen), 16'h0000);
      $display("ignored strobe test done");
   endtask : t_ignored

   task automatic t_irq;
      logic [7:0] q;
      wr(8'hF1, 8'h01);
      events = 8'h01;
      @(negedge clk);
      events = 8'h00;
      repeat (3) @(negedge clk);
      check(16'({int_n_oe, int_n_out}), 16'h0002);
      // Second event lands while the status byte is being driven
      fork
         rd(8'hF0, q);
         begin
            repeat (6) @(negedge clk);
            events = 8'h02;
            @(negedge clk);
            events = 8'h00;
         end
      join
      check(16'(q), 16'h0001);
      repeat (2) @(negedge clk);
      check(16'(int_n_oe), 16'h0000);
      rd(8'hF0, q);
      check(16'(q), 16'h0002);
      rd(8'hF1, q);
      check(16'(q), 16'h0001);
      wr(8'hF2, 8'h01);
      check(16'({drv_hi, int_n_oe, int_n_out}), 16'h0007);
      events = 8'h01;
      @(negedge clk);
      events = 8'h00;
      repeat (3) @(negedge clk);
      check(16'({int_n_oe, int_n_out}), 16'h0002);
      rd(8'hF0, q);
      repeat (2) @(negedge clk);
      check(16'({int_n_oe, int_n_out}), 16'h0003);
      $display("interrupt test done");
   endtask : t_irq

   task automatic t_midreset;
      logic [7:0] q;
      // Reset lands while a read byte is driven and the interrupt drives high
      fork
         rd(8'h3C, q);
         begin
            repeat (6) @(negedge clk);
            check(16'({data_oe, int_n_oe}), 16'h0003);
            rst_n = 1'b0;
            #1;
            check(16'({data_oe, int_n_oe, int_n_out, drv_hi}), 16'h0002);
            repeat (2) @(negedge clk);
            rst_n = 1'b1;
         end
      join
      check(16'({data_oe, int_n_oe, drv_hi}), 16'h0000);
      rd(8'h3C, q);
      check(16'(q), 16'h0099);
      $display("mid-run reset test done");
   endtask : t_midreset

   initial
   begin
      clk         = 1'b0;
      rst_n       = 1'b0;
      style       = 2'b00;
      hw_cfg      = 1'b0;
      ds_mode     = 1'b0;
      events      = 8'h00;
      user_rdata  = 8'h00;
      oe_seen     = 1'b0;
      wr_last     = 16'h0000;
      wr_count    = 0;
      bad_count   = 0;
      check_count = 0;
      t_reset();
      t_style(2'b00);
      t_style(2'b01);
      t_style(2'b00);
      t_ignored();
      t_irq();
      t_midreset();
      wrap_up();
   end

   // Whole run needs well under a thousand clocks
   initial
   begin
      repeat (4000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule : test_async_parallel_host_port

/* File: logic/ahp_host_port.sv */
`timescale 1ns/1ps
`include "ahp_map.svh"

// Notes on behaviour
// - Style pins 00 with config pin low select separate read and write strobes.
// - Style pins 01 with config pin low select data strobe plus direction line.
// - Eight address inputs decode 256 byte locations.
// - Each access moves one byte over the eight-bit two-way data bus.
// - Host holds select low to access; strobes are ignored while select is high.
// - Separate strobes: low read pulse reads, low write pulse writes.
// - Data strobe: low pulse reads with direction high, writes with it low.
// - Open-drain interrupt pulls low while any enabled condition is pending.
// - Reading a latched status register clears its latched bits.
// - An event arriving during a status read survives the clear.
// - Drive select set drives interrupt high when idle; clear lets it float.
// - After reset the interrupt floats until an enabled source is active.
// - While reset is low every bus output driver is released.

module ahp_host_port
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Host bus pins
   input  wire logic             cs_n,
   input  wire logic             rd_ds_n,
   input  wire logic             wr_rw_n,
   input  wire logic [7:0]       addr,
   input  wire logic [7:0]       data_in,
   output logic      [7:0]       data_out,
   output logic                  data_oe,
   // Interrupt pin, open drain
   output logic                  int_n_out,
   output logic                  int_n_oe,
   // Mode straps
   input  wire logic [1:0]       bus_style_select,
   input  wire logic             hardware_config_select,
   // Device core side
   output ahp_pkg::ahp_req_t     req,
   input  wire logic [7:0]       user_rdata,
   input  wire logic [7:0]       status_events,
   output logic                  irq_drive_high_sel
);
   import ahp_pkg::*;

   // ****************************************
   // Pin synchroniser
   // ****************************************
   ahp_pins_t pins_raw;
   ahp_pins_t pins_s1_r;
   ahp_pins_t pins_s2_r;

   always_comb
   begin
      pins_raw = '{cs_n: cs_n, rd_ds_n: rd_ds_n, wr_rw_n: wr_rw_n, addr: addr, data: data_in,
                   style: bus_style_select, hw_cfg: hardware_config_select};
   end

   // Pins idle high on strobes so a reset release never looks like a pulse
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_s1_r <= '{cs_n: 1'b1, rd_ds_n: 1'b1, wr_rw_n: 1'b1, default: '0};
         pins_s2_r <= '{cs_n: 1'b1, rd_ds_n: 1'b1, wr_rw_n: 1'b1, default: '0};
      end
      else
      begin
         pins_s1_r <= pins_raw;
         pins_s2_r <= pins_s1_r;
      end
   end

   // ****************************************
   // Bus style decode
   // ****************************************
   logic style_strobes;
   logic style_dstrobe;
   logic rd_cond;
   logic wr_cond;

   always_comb
   begin
      style_strobes = !pins_s2_r.hw_cfg && (pins_s2_r.style == `AHP_STYLE_STROBES);
      style_dstrobe = !pins_s2_r.hw_cfg && (pins_s2_r.style == `AHP_STYLE_DSTROBE);
      rd_cond = 1'b0;
      wr_cond = 1'b0;
      if (!pins_s2_r.cs_n)
      begin
         if (style_strobes)
         begin
            // read and write pulses
            // Both strobes low at once is treated as a read
            rd_cond = !pins_s2_r.rd_ds_n;
            wr_cond = !pins_s2_r.wr_rw_n && pins_s2_r.rd_ds_n;
         end
         else if (style_dstrobe)
         begin
            rd_cond = !pins_s2_r.rd_ds_n && pins_s2_r.wr_rw_n;
            wr_cond = !pins_s2_r.rd_ds_n && !pins_s2_r.wr_rw_n;
         end
      end
   end

   // ****************************************
   // Local registers and status latch
   // ****************************************
   logic [7:0] status;
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic       clr_r;
   logic       clr_nxt;
   logic [7:0] clr_mask_r;
   logic [7:0] clr_mask_nxt;

   ahp_status_latch u_status
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .events   (status_events),
      .clr      (clr_r),
      .clr_mask (clr_mask_r),
      .status   (status)
   );

   // ****************************************
   // Access sequencer
   // ****************************************
   ahp_state_t state_r;
   ahp_state_t state_nxt;
   ahp_req_t   req_r;
   ahp_req_t   req_nxt;
   logic [7:0] dout_r;
   logic [7:0] dout_nxt;
   logic       doe_r;
   logic       doe_nxt;

   always_comb
   begin
      state_nxt          = state_r;
      req_nxt            = req_r;
      req_nxt.wr         = 1'b0;
      req_nxt.rd         = 1'b0;
      dout_nxt           = dout_r;
      doe_nxt            = 1'b0;
      mask_nxt           = mask_r;
      ctrl_nxt           = ctrl_r;
      clr_nxt            = 1'b0;
      clr_mask_nxt       = clr_mask_r;
      unique case (state_r)
         AHP_IDLE:
         begin
            if (rd_cond)
            begin
               req_nxt.addr = pins_s2_r.addr;
               req_nxt.rd   = 1'b1;
               state_nxt    = AHP_FETCH;
            end
            else if (wr_cond)
            begin
               req_nxt.addr  = pins_s2_r.addr;
               req_nxt.wdata = pins_s2_r.data;
               state_nxt     = AHP_WRITE;
            end
         end
         AHP_FETCH:
         begin
            // Core answers in the cycle its read request is high
            unique case (req_r.addr)
               `AHP_ADDR_STATUS: dout_nxt = status;
               `AHP_ADDR_MASK:   dout_nxt = mask_r;
               `AHP_ADDR_CTRL:   dout_nxt = ctrl_r;
               default:          dout_nxt = user_rdata;
            endcase
            doe_nxt   = rd_cond;
            state_nxt = rd_cond ? AHP_DRIVE : AHP_IDLE;
         end
         AHP_DRIVE:
         begin
            doe_nxt = rd_cond;
            if (!rd_cond)
            begin
               state_nxt = AHP_IDLE;
               // clear what was read
               // Clear at strobe end so the byte on the bus stays stable
               if (req_r.addr == `AHP_ADDR_STATUS)
               begin
                  clr_nxt      = 1'b1;
                  clr_mask_nxt = dout_r;
               end
            end
         end
         AHP_WRITE:
         begin
            if (wr_cond)
            begin
               // Track the bus so the last value before the strobe ends is kept
               req_nxt.addr  = pins_s2_r.addr;
               req_nxt.wdata = pins_s2_r.data;
            end
            else
            begin
               state_nxt = AHP_IDLE;
               unique case (req_r.addr)
                  `AHP_ADDR_STATUS: ;
                  `AHP_ADDR_MASK:   mask_nxt = req_r.wdata;
                  `AHP_ADDR_CTRL:   ctrl_nxt = req_r.wdata;
                  default:          req_nxt.wr = 1'b1;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r    <= AHP_IDLE;
         req_r      <= '0;
         dout_r     <= `AHP_RST_BYTE;
         doe_r      <= 1'b0;
         mask_r     <= `AHP_RST_MASK;
         ctrl_r     <= `AHP_RST_CTRL;
         clr_r      <= 1'b0;
         clr_mask_r <= `AHP_RST_STATUS;
      end
      else
      begin
         state_r    <= state_nxt;
         req_r      <= req_nxt;
         dout_r     <= dout_nxt;
         doe_r      <= doe_nxt;
         mask_r     <= mask_nxt;
         ctrl_r     <= ctrl_nxt;
         clr_r      <= clr_nxt;
         clr_mask_r <= clr_mask_nxt;
      end
   end

   // ****************************************
   // Interrupt pin
   // ****************************************
   logic pending;
   logic int_out_r;
   logic int_out_nxt;
   logic int_oe_r;
   logic int_oe_nxt;

   always_comb
   begin
      pending     = |(status & mask_r);
      int_out_nxt = !pending;
      int_oe_nxt  = pending || ctrl_r[`AHP_CTRL_DRVHI_BIT];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_out_r <= 1'b1;
         int_oe_r  <= 1'b0;
      end
      else
      begin
         int_out_r <= int_out_nxt;
         int_oe_r  <= int_oe_nxt;
      end
   end
   assign data_out           = dout_r;
   assign data_oe            = doe_r;
   assign int_n_out          = int_out_r;
   assign int_n_oe           = int_oe_r;
   assign req                = req_r;
   assign irq_drive_high_sel = ctrl_r[`AHP_CTRL_DRVHI_BIT];

   // ****************************************
   // Checks
   // ****************************************
   sequence s_write_held;
      (state_r == AHP_WRITE) && wr_cond;
   endsequence
   sequence s_write_end;
      (state_r == AHP_WRITE) && !wr_cond;
   endsequence
   a_style_strobes : assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == AHP_IDLE && style_strobes && !pins_s2_r.cs_n && !pins_s2_r.rd_ds_n)
      |=> (state_r == AHP_FETCH) && req_r.rd)
      else $error("Strobe style read not started");

   a_style_dstrobe : assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == AHP_IDLE && style_dstrobe && !pins_s2_r.cs_n && !pins_s2_r.rd_ds_n && !pins_s2_r.wr_rw_n)
      |=> (state_r == AHP_WRITE))
      else $error("Data strobe write not started");

   a_addr_taken : assert property (@(posedge clk) disable iff (!rst_n)
      req_r.rd |-> (req_r.addr == $past(pins_s2_r.addr)))
      else $error("Read address not the sampled pins");

   a_select_ignore : assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == AHP_IDLE && pins_s2_r.cs_n) |=> (state_r == AHP_IDLE))
      else $error("Access started without select");

   a_write_end : assert property (@(posedge clk) disable iff (!rst_n)
      s_write_held ##1 s_write_end |=> (state_r == AHP_IDLE)
      && (req_r.wr == ($past(req_r.addr) < `AHP_ADDR_STATUS || $past(req_r.addr) > `AHP_ADDR_CTRL)))
      else $error("Write not issued at strobe end");

   a_drive_window : assert property (@(posedge clk) disable iff (!rst_n)
      data_oe |-> (state_r == AHP_DRIVE) && $past(rd_cond))
      else $error("Data driven outside a read");

   a_read_byte : assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == AHP_FETCH && rd_cond) ##1 (state_r == AHP_DRIVE) |-> data_oe ##1 (data_out == $past(data_out)))
      else $error("Read byte changed while driven");

   a_irq_low : assert property (@(posedge clk) disable iff (!rst_n)
      pending |=> int_n_oe && !int_n_out)
      else $error("Interrupt not pulled low");

   a_irq_float : assert property (@(posedge clk) disable iff (!rst_n)
      (!pending && !ctrl_r[`AHP_CTRL_DRVHI_BIT]) |=> !int_n_oe)
      else $error("Interrupt driven while inactive");
endmodule : ahp_host_port

/* File: logic/ahp_map.svh */
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH

// Bus style codes on the two style pins
`define AHP_STYLE_STROBES   2'h0
`define AHP_STYLE_DSTROBE   2'h1

// Locations held inside the port itself
`define AHP_ADDR_STATUS     8'hF0
`define AHP_ADDR_MASK       8'hF1
`define AHP_ADDR_CTRL       8'hF2

// Control byte layout
`define AHP_CTRL_DRVHI_BIT  0

// Reset values
`define AHP_RST_STATUS      8'h00
`define AHP_RST_MASK        8'h00
`define AHP_RST_CTRL        8'h00
`define AHP_RST_BYTE        8'h00

`endif

/* File: logic/ahp_pkg.sv */
package ahp_pkg;

   // Host pins as seen after the synchroniser
   typedef struct packed {
      logic       cs_n;
      logic       rd_ds_n;
      logic       wr_rw_n;
      logic [7:0] addr;
      logic [7:0] data;
      logic [1:0] style;
      logic       hw_cfg;
   } ahp_pins_t;

   // Register request towards the device core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ahp_req_t;

   // Gray codes along idle, fetch, drive; write sits one step from idle
   typedef enum logic [1:0] {
      AHP_IDLE   = 2'b00,
      AHP_FETCH  = 2'b01,
      AHP_DRIVE  = 2'b11,
      AHP_WRITE  = 2'b10
   } ahp_state_t;

endpackage : ahp_pkg

/* File: logic/ahp_status_latch.sv */
`timescale 1ns/1ps
`include "ahp_map.svh"

module ahp_status_latch
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Events and clear
   input  wire logic [7:0] events,
   input  wire logic       clr,
   input  wire logic [7:0] clr_mask,
   // Latched state
   output logic      [7:0] status
);
   import ahp_pkg::*;

   logic [7:0] status_r;
   logic [7:0] status_nxt;

   // Only bits the host actually saw are cleared, and a new event wins
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_bit
         always_comb
         begin
            status_nxt[gi] = events[gi] | (status_r[gi] & ~(clr & clr_mask[gi]));
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_r <= `AHP_RST_STATUS;
      else
         status_r <= status_nxt;
   end

   assign status = status_r;

   a_read_clears : assert property (@(posedge clk) disable iff (!rst_n)
      (clr && (clr_mask != 8'h00)) |=> ((status_r & $past(clr_mask) & ~$past(events)) == 8'h00))
      else $error("Read status bits not cleared");

   a_event_kept : assert property (@(posedge clk) disable iff (!rst_n)
      (events != 8'h00) |=> ((status_r & $past(events)) == $past(events)))
      else $error("Status event lost");

endmodule : ahp_status_latch
